/* cipu_pkg.sv */
// Purpose: shared constants and carriers for the interrupt and protect unit
// Assumes: 16-bit words, 15-bit memory addresses, 100 MHz mclk
// Notes: vectors are octal memory locations

package cipu_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned SC_W = 6;
  localparam int unsigned IO_N = 48;

  // ************************************************************
  // vector locations
  // ************************************************************
  localparam logic [ADDR_W-1:0] VEC_PARITY = 15'o00005;
  localparam logic [ADDR_W-1:0] VEC_ILLEGAL = 15'o00010;
  localparam logic [ADDR_W-1:0] VEC_PROTECT = 15'o00007;
  localparam logic [ADDR_W-1:0] VEC_PWRFAIL = 15'o00004;
  localparam logic [ADDR_W-1:0] VEC_SPECIAL = 15'o00017;
  localparam logic [ADDR_W-1:0] VEC_TBASE = 15'o00006;
  localparam logic [ADDR_W-1:0] VEC_RSV_LO = 15'o00011;
  localparam logic [ADDR_W-1:0] VEC_RSV_HI = 15'o00016;
  localparam logic [SC_W-1:0] SC_IO_LO = 6'o20;
  localparam logic [SC_W-1:0] SC_IO_HI = 6'o77;
  localparam logic [SC_W-1:0] SC_CPU = 6'o01;

  // ************************************************************
  // accumulator memory addresses
  // ************************************************************
  localparam logic [ADDR_W-1:0] ADDR_ACC_A = 15'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ACC_B = 15'h0001;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;

  // internal source index
  typedef enum logic [2:0] {
    CIPU_SRC_PARITY = 3'h0,
    CIPU_SRC_ILLEGAL = 3'h1,
    CIPU_SRC_PROTECT = 3'h2,
    CIPU_SRC_PWRFAIL = 3'h3,
    CIPU_SRC_SPECIAL = 3'h4,
    CIPU_SRC_TBASE = 3'h5
  } cipu_src_e;

  localparam int unsigned SRC_N = 6;

  // core access to check
  typedef struct packed {
    logic valid;
    logic is_write;
    logic is_jump;
    logic is_io;
    logic [ADDR_W-1:0] addr;
    logic [SC_W-1:0] sc;
    logic [ADDR_W-1:0] pc;
  } cipu_access_s;

  // vector grant towards the core
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] vector;
  } cipu_grant_s;

  // memory write of the violating address
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } cipu_memwr_s;

endpackage : cipu_pkg

/* cipu_tick.sv */
// Purpose: time base generator, one pulse before each wrap
// Assumes: mclk at the package rate
// Notes: period shortened through the parameter in simulation

`timescale 1ns/1ps

module cipu_tick #(
  parameter int unsigned PERIOD = cipu_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // tick out
  output logic tick
);

  localparam int unsigned CW = $clog2(PERIOD);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb
  begin
    tick_d = (cnt_q == CW'(PERIOD - 2));
    if (cnt_q == CW'(PERIOD - 1))
    begin
      cnt_d = '0;
    end
    else
    begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : cipu_tick

/* cipu_core.sv */
// Purpose: interrupt ranking, vectoring and memory protect for the cpu
// Assumes: core presents one access per cycle and pulses boundaries
// Notes: grant waits for an instruction boundary with no dma in progress
//
// How it works
// - parity 05, illegal 10, protect 07 first
// - then power fail 04, special 17, tick 06
// - 11-16 reserved; i/o by select code 20-77
// - power-fail warning while running vectors to 04
// - protect blocks writes/jumps at or below fence, except accumulator addresses 0 and 1
// - protect refuses i/o except select code 01
// - violation interrupts and stores address at 07
// - tick request every 10 ms before wrap
// - unrecognised fetched opcode requests illegal interrupt
// - two 16-bit accumulators, also memory addressed
// - acknowledged source executes its vector location
// - service deferred until instruction/dma cycle ends

`timescale 1ns/1ps

module cipu_core #(
  parameter int unsigned TICK_PERIOD = cipu_pkg::TICK_CYCLES,
  parameter int unsigned IO_CNT = cipu_pkg::IO_N
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // event sources
  input wire logic parity_err,
  input wire logic illegal_op,
  input wire logic pwr_warn,
  input wire logic running,
  input wire logic special_req,
  // i/o requests, bit k has select code io_sc[k], bit 0 nearest
  input wire logic [IO_CNT-1:0] io_req,
  input wire logic [IO_CNT-1:0][cipu_pkg::SC_W-1:0] io_sc,
  // core flow
  input wire logic boundary,
  input wire logic dma_busy,
  input wire logic grant_ack,
  input wire cipu_pkg::cipu_access_s access,
  // protect control
  input wire logic fence_load,
  input wire logic [cipu_pkg::ADDR_W-1:0] fence_in,
  input wire logic protect_set,
  input wire logic protect_clr,
  // accumulators
  input wire logic acc_we,
  input wire logic acc_sel,
  input wire logic [cipu_pkg::WORD_W-1:0] acc_wdata,
  // results
  output cipu_pkg::cipu_grant_s grant,
  output cipu_pkg::cipu_memwr_s memwr,
  output logic access_block,
  output logic protect_on,
  output logic [cipu_pkg::ADDR_W-1:0] fence,
  output logic [cipu_pkg::WORD_W-1:0] acc_a,
  output logic [cipu_pkg::WORD_W-1:0] acc_b
);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [cipu_pkg::ADDR_W-1:0] src_vec(input int unsigned i);
    case (i)
      0: src_vec = cipu_pkg::VEC_PARITY;
      1: src_vec = cipu_pkg::VEC_ILLEGAL;
      2: src_vec = cipu_pkg::VEC_PROTECT;
      3: src_vec = cipu_pkg::VEC_PWRFAIL;
      4: src_vec = cipu_pkg::VEC_SPECIAL;
      default: src_vec = cipu_pkg::VEC_TBASE;
    endcase
  endfunction : src_vec

  function automatic logic is_acc(input logic [cipu_pkg::ADDR_W-1:0] a);
    is_acc = (a == cipu_pkg::ADDR_ACC_A) || (a == cipu_pkg::ADDR_ACC_B);
  endfunction : is_acc

  typedef enum logic [1:0] {
    CIPU_IDLE = 2'b00,
    CIPU_WAIT = 2'b01,
    CIPU_OFFER = 2'b11
  } cipu_state_e;

  // ************************************************************
  // state
  // ************************************************************
  logic tick;
  logic [cipu_pkg::SRC_N-1:0] pend_q;
  logic [cipu_pkg::SRC_N-1:0] pend_d;
  logic pwr_q;
  logic pwr_d;
  cipu_state_e st_q;
  cipu_state_e st_d;
  cipu_pkg::cipu_grant_s grant_q;
  cipu_pkg::cipu_grant_s grant_d;
  int unsigned win_q;
  int unsigned win_d;
  logic win_int_q;
  logic win_int_d;
  cipu_pkg::cipu_memwr_s memwr_q;
  cipu_pkg::cipu_memwr_s memwr_d;
  logic prot_q;
  logic prot_d;
  logic [cipu_pkg::ADDR_W-1:0] fence_q;
  logic [cipu_pkg::ADDR_W-1:0] fence_d;
  logic [cipu_pkg::WORD_W-1:0] acc_a_q;
  logic [cipu_pkg::WORD_W-1:0] acc_a_d;
  logic [cipu_pkg::WORD_W-1:0] acc_b_q;
  logic [cipu_pkg::WORD_W-1:0] acc_b_d;
  logic violate;
  logic io_ok;

  cipu_tick #(
    .PERIOD(TICK_PERIOD)
  ) u_tick (
    .mclk(mclk),
    .reset(reset),
    .tick(tick)
  );

  // ************************************************************
  // protect check
  // ************************************************************
  always_comb
  begin
    violate = 1'b0;
    if (access.valid && prot_q)
    begin
      if ((access.is_write || access.is_jump) && (access.addr <= fence_q) && !is_acc(access.addr))
      begin
        violate = 1'b1;
      end
      if (access.is_io && (access.sc != cipu_pkg::SC_CPU))
      begin
        violate = 1'b1;
      end
    end
  end

  assign access_block = violate;

  // ************************************************************
  // pending, protect, accumulators
  // ************************************************************
  always_comb
  begin
    pwr_d = pwr_warn;
    pend_d = pend_q;
    // set wins over clear: clear first, then set
    if (st_q == CIPU_OFFER && grant_ack && win_int_q)
    begin
      pend_d[win_q] = 1'b0;
    end
    if (parity_err)
    begin
      pend_d[cipu_pkg::CIPU_SRC_PARITY] = 1'b1;
    end
    if (illegal_op)
    begin
      pend_d[cipu_pkg::CIPU_SRC_ILLEGAL] = 1'b1;
    end
    if (violate)
    begin
      pend_d[cipu_pkg::CIPU_SRC_PROTECT] = 1'b1;
    end
    if (pwr_warn && !pwr_q && running)
    begin
      pend_d[cipu_pkg::CIPU_SRC_PWRFAIL] = 1'b1;
    end
    if (special_req)
    begin
      pend_d[cipu_pkg::CIPU_SRC_SPECIAL] = 1'b1;
    end
    if (tick)
    begin
      pend_d[cipu_pkg::CIPU_SRC_TBASE] = 1'b1;
    end
    memwr_d.valid = violate;
    memwr_d.addr = cipu_pkg::VEC_PROTECT;
    memwr_d.data = {1'b0, access.pc};
    prot_d = prot_q;
    if (protect_clr)
    begin
      prot_d = 1'b0;
    end
    if (protect_set)
    begin
      prot_d = 1'b1;
    end
    fence_d = fence_load ? fence_in : fence_q;
    acc_a_d = (acc_we && !acc_sel) ? acc_wdata : acc_a_q;
    acc_b_d = (acc_we && acc_sel) ? acc_wdata : acc_b_q;
  end

  // ************************************************************
  // arbitration
  // ************************************************************
  always_comb
  begin
    st_d = st_q;
    grant_d = grant_q;
    win_d = win_q;
    win_int_d = win_int_q;
    case (st_q)
      CIPU_IDLE:
      begin
        if ((|pend_q) || (|io_req))
        begin
          st_d = CIPU_WAIT;
        end
      end
      CIPU_WAIT:
      begin
        if (boundary && !dma_busy)
        begin
          grant_d.valid = 1'b0;
          for (int i = cipu_pkg::SRC_N - 1; i >= 0; i--)
          begin
            if (pend_q[i])
            begin
              grant_d.valid = 1'b1;
              grant_d.vector = src_vec(i);
              win_d = i;
              win_int_d = 1'b1;
            end
          end
          if (!(|pend_q))
          begin
            for (int k = IO_CNT - 1; k >= 0; k--)
            begin
              if (io_req[k] && io_sc[k] >= cipu_pkg::SC_IO_LO)
              begin
                grant_d.valid = 1'b1;
                grant_d.vector = {{(cipu_pkg::ADDR_W - cipu_pkg::SC_W){1'b0}}, io_sc[k]};
                win_d = k;
                win_int_d = 1'b0;
              end
            end
          end
          st_d = grant_d.valid ? CIPU_OFFER : CIPU_IDLE;
        end
      end
      CIPU_OFFER:
      begin
        if (grant_ack)
        begin
          grant_d.valid = 1'b0;
          st_d = CIPU_IDLE;
        end
      end
      default:
      begin
        st_d = CIPU_IDLE;
        grant_d.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pend_q <= '0;
      pwr_q <= 1'b0;
      st_q <= CIPU_IDLE;
      grant_q <= '0;
      win_q <= 0;
      win_int_q <= 1'b0;
      memwr_q <= '0;
      prot_q <= 1'b0;
      fence_q <= '0;
      acc_a_q <= cipu_pkg::ZERO_WORD;
      acc_b_q <= cipu_pkg::ZERO_WORD;
    end
    else
    begin
      pend_q <= pend_d;
      pwr_q <= pwr_d;
      st_q <= st_d;
      grant_q <= grant_d;
      win_q <= win_d;
      win_int_q <= win_int_d;
      memwr_q <= memwr_d;
      prot_q <= prot_d;
      fence_q <= fence_d;
      acc_a_q <= acc_a_d;
      acc_b_q <= acc_b_d;
    end
  end

  assign grant = grant_q;
  assign memwr = memwr_q;
  assign protect_on = prot_q;
  assign fence = fence_q;
  assign acc_a = acc_a_q;
  assign acc_b = acc_b_q;

endmodule : cipu_core

/* cipu_chk.sv */
// Purpose: port checks of the interrupt and protect unit
// Assumes: bound to cipu_core, one clock domain
// Notes: access_block is combinational
`timescale 1ns/1ps
module cipu_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // core flow
  input wire logic boundary,
  input wire logic dma_busy,
  input wire logic grant_ack,
  input wire cipu_pkg::cipu_access_s access,
  // results
  input wire cipu_pkg::cipu_grant_s grant,
  input wire cipu_pkg::cipu_memwr_s memwr,
  input wire logic access_block,
  input wire logic protect_on,
  input wire logic [cipu_pkg::ADDR_W-1:0] fence
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // ********
  // protect
  // ********
  sequence s_viol;
    access.valid && access_block;
  endsequence
  sequence s_save;
    memwr.valid && memwr.addr == 15'h0007 && memwr.data == {1'b0, $past(access.pc)};
  endsequence
  AST_SAVE: assert property (s_viol |=> s_save)
    else $error("violation address not saved");
  AST_FENCE: assert property (access.valid && protect_on && (access.is_write || access.is_jump) && !access.is_io
    && access.addr > 15'h0001 |-> access_block == (access.addr <= fence))
    else $error("fence check wrong");
  AST_ACCX: assert property (access.valid && !access.is_io && access.addr <= 15'h0001 |-> !access_block)
    else $error("accumulator access blocked");
  AST_IOBLK: assert property (access.valid && access.is_io && protect_on |-> access_block == (access.sc != 6'h01))
    else $error("io check wrong");
  AST_OFF: assert property (!protect_on |-> !access_block)
    else $error("block while unprotected");
  // ********
  // grant
  // ********
  AST_DEFER: assert property ($rose(grant.valid) |-> $past(boundary) && !$past(dma_busy))
    else $error("grant off boundary");
  AST_HOLD: assert property (grant.valid && !grant_ack |=> grant.valid && $stable(grant.vector))
    else $error("grant not held");
  AST_DROP: assert property (grant.valid && grant_ack |=> !grant.valid)
    else $error("grant kept after ack");
  AST_RSV: assert property (grant.valid |-> !(grant.vector inside {[15'h0009:15'h000e]}) && grant.vector <= 15'h003f)
    else $error("vector out of range");
endmodule : cipu_chk

bind cipu_core cipu_chk u_cipu_chk (.*);

/* cipu_cards.sv */
// Purpose: interface cards and power module on the backplane
// Assumes: a card holds its request until its vector is acknowledged
// Notes: select codes run against slot order
`timescale 1ns/1ps
module cipu_cards (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // bench control
  input wire logic [cipu_pkg::IO_N-1:0] raise,
  input wire logic pf,
  // core side
  input wire cipu_pkg::cipu_grant_s grant,
  input wire logic grant_ack,
  // backplane
  output logic [cipu_pkg::IO_N-1:0] io_req,
  output logic [cipu_pkg::IO_N-1:0][cipu_pkg::SC_W-1:0] io_sc,
  output logic pwr_warn
);
  always_comb
  begin
    for (int k = 0; k < cipu_pkg::IO_N; k++)
    begin
      io_sc[k] = 6'h3f - 6'(k);
    end
  end
  always_ff @(posedge mclk)
  begin
    pwr_warn <= pf & ~reset;
    for (int k = 0; k < cipu_pkg::IO_N; k++)
    begin
      if (reset || (grant.valid && grant_ack && grant.vector == 15'(io_sc[k])))
        io_req[k] <= 1'b0;
      else if (raise[k])
        io_req[k] <= 1'b1;
    end
  end
endmodule : cipu_cards

/* cipu_tb.sv */
// Purpose: self-checking bench of the interrupt and protect unit
// Assumes: tick period cut to TP cycles
// Notes: boundary held high outside the deferral check
`timescale 1ns/1ps
module tb;
  localparam int TP = 40;
  logic mclk, reset, parity_err, illegal_op, pwr_warn, running, special_req, pf;
  logic boundary, dma_busy, grant_ack, fence_load, protect_set, protect_clr, acc_we, acc_sel;
  logic access_block, protect_on;
  logic [cipu_pkg::IO_N-1:0] io_req, raise;
  logic [cipu_pkg::IO_N-1:0][cipu_pkg::SC_W-1:0] io_sc;
  logic [cipu_pkg::ADDR_W-1:0] fence, fence_in;
  logic [cipu_pkg::WORD_W-1:0] acc_a, acc_b, acc_wdata;
  cipu_pkg::cipu_access_s access;
  cipu_pkg::cipu_grant_s grant;
  cipu_pkg::cipu_memwr_s memwr;
  int fail_count, total_checks, cyc;

  cipu_core #(.TICK_PERIOD(TP)) u_cipu_core (.*);
  cipu_cards u_cipu_cards (.*);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // waits for a grant, acks it, skips ticks not asked for
  task automatic serve(input logic [14:0] v, output int t);
    logic [14:0] g;
    t = -1;
    for (int i = 0; i < 80 && t < 0; i++)
    begin
      @(posedge mclk);
      #1;
      if (grant.valid === 1'b1)
      begin
        g = grant.vector;
        @(posedge mclk);
        grant_ack <= 1'b1;
        @(posedge mclk);
        grant_ack <= 1'b0;
        if (g != 15'h0006 || v == 15'h0006)
          t = cyc;
      end
    end
    chk("vector", 32'(v), 32'(g));
  endtask : serve

  task automatic acc_chk(input logic w, j, io, input logic [14:0] a, input logic [5:0] s, input logic e);
    @(posedge mclk);
    access <= '{1'b1, w, j, io, a, s, 15'h0123};
    #1;
    chk("block", 32'(e), 32'(access_block));
    @(posedge mclk);
    access <= '0;
    #1;
    if (e)
      chk("save", 32'h8007_0123, 32'(memwr));
    else
      chk("no save", 32'h0, 32'(memwr.valid));
  endtask : acc_chk

  task automatic t_rank();
    int t;
    logic [14:0] order[7] = '{15'h0005, 15'h0008, 15'h0007, 15'h0004, 15'h000f, 15'h003f, 15'h003d};
    @(posedge mclk);
    dma_busy <= 1'b1;
    fence_load <= 1'b1;
    fence_in <= 15'h0064;
    protect_set <= 1'b1;
    raise <= 48'h5;
    @(posedge mclk);
    fence_load <= 1'b0;
    protect_set <= 1'b0;
    raise <= '0;
    parity_err <= 1'b1;
    illegal_op <= 1'b1;
    special_req <= 1'b1;
    pf <= 1'b1;
    @(posedge mclk);
    parity_err <= 1'b0;
    illegal_op <= 1'b0;
    special_req <= 1'b0;
    acc_chk(1'b1, 1'b0, 1'b0, 15'h0032, 6'h00, 1'b1);
    repeat (4) @(posedge mclk);
    #1;
    chk("dma hold", 32'h0, 32'(grant.valid));
    chk("fence", 32'h64, 32'(fence));
    chk("protect on", 32'h1, 32'(protect_on));
    @(posedge mclk);
    dma_busy <= 1'b0;
    boundary <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("boundary hold", 32'h0, 32'(grant.valid));
    @(posedge mclk);
    boundary <= 1'b1;
    foreach (order[i])
      serve(order[i], t);
    $display("rank test done");
  endtask : t_rank

  task automatic t_prot();
    int t;
    acc_chk(1'b1, 1'b0, 1'b0, 15'h0064, 6'h00, 1'b1);
    acc_chk(1'b0, 1'b1, 1'b0, 15'h0065, 6'h00, 1'b0);
    acc_chk(1'b0, 1'b1, 1'b0, 15'h0032, 6'h00, 1'b1);
    acc_chk(1'b1, 1'b0, 1'b0, 15'h0001, 6'h00, 1'b0);
    acc_chk(1'b0, 1'b0, 1'b1, 15'h0000, 6'h01, 1'b0);
    acc_chk(1'b0, 1'b0, 1'b1, 15'h0000, 6'h10, 1'b1);
    serve(15'h0007, t);
    @(posedge mclk);
    protect_clr <= 1'b1;
    @(posedge mclk);
    protect_clr <= 1'b0;
    acc_chk(1'b1, 1'b0, 1'b0, 15'h0032, 6'h00, 1'b0);
    chk("protect off", 32'h0, 32'(protect_on));
    $display("protect test done");
  endtask : t_prot

  task automatic t_tick();
    int t1;
    int t2;
    serve(15'h0006, t1);
    serve(15'h0006, t2);
    chk("tick period", 32'(TP), 32'(t2 - t1));
    $display("tick test done");
  endtask : t_tick

  // power-fail warning edge while halted must not interrupt
  task automatic t_run();
    @(posedge mclk);
    pf <= 1'b0;
    running <= 1'b0;
    @(posedge mclk);
    pf <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("run gate", 32'h0, 32'(grant.valid));
    $display("halted power fail test done");
  endtask : t_run

  task automatic t_acc();
    @(posedge mclk);
    acc_we <= 1'b1;
    acc_wdata <= 16'hbeef;
    @(posedge mclk);
    acc_sel <= 1'b1;
    acc_wdata <= 16'h1357;
    @(posedge mclk);
    acc_we <= 1'b0;
    #1;
    chk("acc", 32'hbeef_1357, {acc_a, acc_b});
    $display("accumulator test done");
  endtask : t_acc

  initial
  begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    test_done();
  end

  initial
  begin
    {reset, running, boundary} = 3'h7;
    {parity_err, illegal_op, special_req, pf, dma_busy, grant_ack} = 6'h00;
    {fence_load, protect_set, protect_clr, acc_we, acc_sel} = 5'h00;
    raise = '0;
    fence_in = '0;
    acc_wdata = '0;
    access = '0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk("reset", 32'h0, 32'({grant.valid, memwr.valid, protect_on, fence}));
    t_rank();
    t_prot();
    t_tick();
    t_run();
    t_acc();
    test_done();
  end
endmodule : tb
